/* inc/flash_pd_pkg.sv */
package flash_pd_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock rate and timer layout.
	////////////////////////////////////////////////////////////////////////

	// Core clock rate in MHz.
	localparam int CORE_CLK_MHZ = 125;
	// Width of the mode timer.
	localparam int TMR_W = 16;

	////////////////////////////////////////////////////////////////////////
	// Mode timings in ns, and the cycle counts derived from them.
	////////////////////////////////////////////////////////////////////////

	// Longest time to enter deep power-down.
	localparam int DEEP_ENTRY_MAX_NS  = 3000;
	// Longest time to resume from deep power-down.
	localparam int DEEP_RESUME_MAX_NS = 5000;
	// Longest time to enter ultra-deep power-down.
	localparam int ULTRA_ENTRY_MAX_NS = 3000;
	// Longest time to leave ultra-deep power-down.
	localparam int ULTRA_EXIT_MAX_NS  = 100000;
	// Least low time of the chip-select wake pulse.
	localparam int WAKE_PULSE_MIN_LOW_NS = 20;

	// Longest times round down, least times round up, none below one.
	localparam int DEEP_ENTRY_CYC_RAW  = DEEP_ENTRY_MAX_NS * CORE_CLK_MHZ / 1000;
	localparam int DEEP_ENTRY_CYC      = (DEEP_ENTRY_CYC_RAW < 1) ? 1 :
	                                     DEEP_ENTRY_CYC_RAW;
	localparam int DEEP_RESUME_CYC_RAW = DEEP_RESUME_MAX_NS * CORE_CLK_MHZ / 1000;
	localparam int DEEP_RESUME_CYC     = (DEEP_RESUME_CYC_RAW < 1) ? 1 :
	                                     DEEP_RESUME_CYC_RAW;
	localparam int ULTRA_ENTRY_CYC_RAW = ULTRA_ENTRY_MAX_NS * CORE_CLK_MHZ / 1000;
	localparam int ULTRA_ENTRY_CYC     = (ULTRA_ENTRY_CYC_RAW < 1) ? 1 :
	                                     ULTRA_ENTRY_CYC_RAW;
	localparam int ULTRA_EXIT_CYC_RAW  = ULTRA_EXIT_MAX_NS * CORE_CLK_MHZ / 1000;
	localparam int ULTRA_EXIT_CYC      = (ULTRA_EXIT_CYC_RAW < 1) ? 1 :
	                                     ULTRA_EXIT_CYC_RAW;
	localparam int WAKE_PULSE_CYC_RAW  =
		(WAKE_PULSE_MIN_LOW_NS * CORE_CLK_MHZ + 999) / 1000;
	localparam int WAKE_PULSE_CYC      = (WAKE_PULSE_CYC_RAW < 1) ? 1 :
	                                     WAKE_PULSE_CYC_RAW;

	////////////////////////////////////////////////////////////////////////
	// Opcodes, mode codes and states.
	////////////////////////////////////////////////////////////////////////

	// Opcodes recognised by the power logic.
	localparam logic [7:0] OP_DEEP_ENTER  = 8'h00_B9;
	localparam logic [7:0] OP_DEEP_RESUME = 8'h00_AB;
	localparam logic [7:0] OP_ULTRA_ENTER = 8'h00_79;

	// Mode codes shown on the mode output.
	localparam logic [1:0] MODE_STANDBY = 2'h0;
	localparam logic [1:0] MODE_DEEP    = 2'h1;
	localparam logic [1:0] MODE_ULTRA   = 2'h2;

	// Values of the synchroniser flops after reset: chip select idle high.
	localparam logic [1:0] SYNC_RST_VAL = 2'h1;

	// Power states.
	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_DEEP_ENTRY,
		ST_DEEP,
		ST_DEEP_RESUME,
		ST_ULTRA_ENTRY,
		ST_ULTRA,
		ST_ULTRA_WAKE,
		ST_ULTRA_EXIT
	} pm_state_t;

endpackage

/* rtl/flash_power_down_control.sv */
`timescale 1ns/1ps

module flash_power_down_control
	import flash_pd_pkg::*;
#(
	parameter int unsigned DEEP_ENTRY_CYC_P  = DEEP_ENTRY_CYC,
	parameter int unsigned DEEP_RESUME_CYC_P = DEEP_RESUME_CYC,
	parameter int unsigned ULTRA_ENTRY_CYC_P = ULTRA_ENTRY_CYC,
	parameter int unsigned ULTRA_EXIT_CYC_P  = ULTRA_EXIT_CYC,
	parameter int unsigned WAKE_PULSE_CYC_P  = WAKE_PULSE_CYC
) (
	// Core clock and synchronous reset.
	input  wire logic       core_clk_i,
	input  wire logic       srst_i,
	// Serial link pins from the host.
	input  wire logic       spi_sck_i,
	input  wire logic       spi_cs_n_i,
	input  wire logic       spi_mosi_i,
	// Internal device status and buffer bookkeeping.
	input  wire logic       busy_i,
	input  wire logic       buf_reload_i,
	// Power status outputs.
	output logic      [1:0] mode_o,
	output logic            active_o,
	output logic            ready_o,
	output logic            cmd_enable_o,
	output logic            sram_lost_o
);

	////////////////////////////////////////////////////////////////////////
	// Timer limits, held as last-count values at the timer width.
	////////////////////////////////////////////////////////////////////////

	// Each limit is the timer value seen in the last cycle of its wait.
	localparam logic [TMR_W-1:0] DEEP_LIM   = TMR_W'(DEEP_ENTRY_CYC_P - 1);
	localparam logic [TMR_W-1:0] RESUME_LIM = TMR_W'(DEEP_RESUME_CYC_P - 1);
	localparam logic [TMR_W-1:0] ULTRA_LIM  = TMR_W'(ULTRA_ENTRY_CYC_P - 1);
	localparam logic [TMR_W-1:0] EXIT_LIM   = TMR_W'(ULTRA_EXIT_CYC_P - 1);
	localparam logic [TMR_W-1:0] PULSE_LIM  = TMR_W'(WAKE_PULSE_CYC_P - 1);
	localparam logic [TMR_W-1:0] TMR_MAX    = '1;

	////////////////////////////////////////////////////////////////////////
	// Link domain: opcode capture on the serial clock.
	////////////////////////////////////////////////////////////////////////

	logic [7:0] shift_reg;    // First eight bits of the frame.
	logic [2:0] bitcnt_reg;   // Bit count modulo eight.
	logic       full_reg;     // Whole opcode has been shifted in.
	logic       any_bit_reg;  // At least one clock edge in this frame.
	logic       link_clr_reg; // Core-driven clear of the link state.

	// The link state is cleared from the core while chip select is high,
	// so the serial clock is idle and the clear cannot race an edge.
	always_ff @(posedge spi_sck_i or posedge link_clr_reg) begin
		if (link_clr_reg) begin
			bitcnt_reg  <= 3'h0;
			any_bit_reg <= 1'b0;
		end else begin
			bitcnt_reg  <= bitcnt_reg + 3'h1;
			any_bit_reg <= 1'b1;
		end
	end

	// Only the opcode is kept; later bits of the frame are ignored.
	always_ff @(posedge spi_sck_i or posedge link_clr_reg) begin
		if (link_clr_reg) begin
			shift_reg <= 8'h00;
			full_reg  <= 1'b0;
		end else if (!full_reg) begin
			shift_reg <= {shift_reg[6:0], spi_mosi_i};
			if (bitcnt_reg == 3'h7) begin
				full_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Crossing into the core domain.
	////////////////////////////////////////////////////////////////////////

	logic [1:0] sync_q;   // Synchronised {any bit, chip select}.
	logic       cs_hi_s;  // Chip select inactive, synchronised.
	logic       any_s;    // A bit has arrived in this frame.
	logic       cs_hi_d;  // Previous synchronised chip select.

	// Chip select and the bit-seen flag are levels, so two flops suffice.
	pd_sync #(
		.WIDTH   (2),
		.RST_VAL (SYNC_RST_VAL)
	) u_sync (
		.clk_i   (core_clk_i),
		.srst_i  (srst_i),
		.async_i ({any_bit_reg, spi_cs_n_i}),
		.sync_o  (sync_q)
	);

	assign cs_hi_s = sync_q[0];
	assign any_s   = sync_q[1];

	// Delayed copy of chip select for edge detection.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			cs_hi_d <= 1'b1;
		end else begin
			cs_hi_d <= cs_hi_s;
		end
	end

	// Frame boundaries seen in the core domain.
	logic frame_start;
	logic frame_end;
	assign frame_start = cs_hi_d && !cs_hi_s;
	assign frame_end   = !cs_hi_d && cs_hi_s;

	// The opcode word is read only after chip select has gone high and
	// been synchronised, when the serial clock is still; it is stable.
	logic cmd_good;
	assign cmd_good = full_reg && (bitcnt_reg == 3'h0);

	// Pulse the link clear in the cycle after a frame has been decoded.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			link_clr_reg <= 1'b1;
		end else begin
			link_clr_reg <= frame_end;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power state machine.
	////////////////////////////////////////////////////////////////////////

	pm_state_t        state_reg;    // Current power state.
	pm_state_t        state_next;   // Next power state.
	logic [TMR_W-1:0] tmr_reg;      // Cycles spent in the current state.
	logic             frame_ok_reg; // Current frame may carry a command.

	// Next state from frame ends, timers and the busy input.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_STANDBY: begin
				// Entry needs a whole aligned opcode and no timed job.
				if (frame_end && frame_ok_reg && cmd_good && !busy_i) begin
					if (shift_reg == OP_DEEP_ENTER) begin
						state_next = ST_DEEP_ENTRY;
					end else if (shift_reg == OP_ULTRA_ENTER) begin
						state_next = ST_ULTRA_ENTRY;
					end
				end
			end
			ST_DEEP_ENTRY: begin
				if (tmr_reg >= DEEP_LIM) begin
					state_next = ST_DEEP;
				end
			end
			ST_DEEP: begin
				// Only the resume opcode is heard here.
				if (frame_end && frame_ok_reg && cmd_good &&
				    shift_reg == OP_DEEP_RESUME) begin
					state_next = ST_DEEP_RESUME;
				end
			end
			ST_DEEP_RESUME: begin
				if (tmr_reg >= RESUME_LIM) begin
					state_next = ST_STANDBY;
				end
			end
			ST_ULTRA_ENTRY: begin
				if (tmr_reg >= ULTRA_LIM) begin
					state_next = ST_ULTRA;
				end
			end
			ST_ULTRA: begin
				// No opcode is decoded; only chip select wakes the device.
				if (frame_start) begin
					state_next = ST_ULTRA_WAKE;
				end
			end
			ST_ULTRA_WAKE: begin
				// A long enough pulse starts the exit; a short one is lost.
				if (frame_end) begin
					state_next = (tmr_reg >= PULSE_LIM) ? ST_ULTRA_EXIT :
					             ST_ULTRA;
				end else if (tmr_reg >= EXIT_LIM) begin
					state_next = ST_STANDBY;
				end
			end
			ST_ULTRA_EXIT: begin
				if (tmr_reg >= EXIT_LIM) begin
					state_next = ST_STANDBY;
				end
			end
			default: begin
				state_next = ST_STANDBY;
			end
		endcase
	end

	// State register; reset always lands in standby.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state_reg <= ST_STANDBY;
		end else begin
			state_reg <= state_next;
		end
	end

	// Timer restarts on every state change and saturates.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			tmr_reg <= '0;
		end else if (state_next != state_reg) begin
			tmr_reg <= '0;
		end else if (tmr_reg != TMR_MAX) begin
			tmr_reg <= tmr_reg + TMR_W'(1);
		end
	end

	// A frame may carry a command only if it began in a listening state.
	// A held-low wake hands the frame on only if no bit came early.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			frame_ok_reg <= 1'b0;
		end else if (frame_start) begin
			frame_ok_reg <= (state_reg == ST_STANDBY) ||
			                (state_reg == ST_DEEP);
		end else if (state_reg == ST_ULTRA_WAKE &&
		             state_next == ST_STANDBY) begin
			frame_ok_reg <= !any_s;
		end else if (state_next != state_reg) begin
			frame_ok_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status outputs.
	////////////////////////////////////////////////////////////////////////

	// Mode shown to the rest of the device.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			mode_o <= MODE_STANDBY;
		end else begin
			case (state_reg)
				ST_DEEP, ST_DEEP_RESUME: begin
					mode_o <= MODE_DEEP;
				end
				ST_ULTRA, ST_ULTRA_WAKE, ST_ULTRA_EXIT: begin
					mode_o <= MODE_ULTRA;
				end
				default: begin
					mode_o <= MODE_STANDBY;
				end
			endcase
		end
	end

	// Active only in standby with a frame open or a timed job running.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			active_o <= 1'b0;
		end else begin
			active_o <= (state_reg == ST_STANDBY) &&
			            (!cs_hi_s || busy_i);
		end
	end

	// Ready flag, the inverse of the busy input.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ready_o <= 1'b1;
		end else begin
			ready_o <= !busy_i;
		end
	end

	// Normal commands are allowed only in standby, never mid-ignored frame.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			cmd_enable_o <= 1'b0;
		end else begin
			cmd_enable_o <= (state_reg == ST_STANDBY) &&
			                (cs_hi_s || frame_ok_reg);
		end
	end

	// Buffer loss flag; setting on ultra entry wins over a reload.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			sram_lost_o <= 1'b0;
		end else if (state_reg == ST_ULTRA_ENTRY &&
		             state_next == ST_ULTRA) begin
			sram_lost_o <= 1'b1;
		end else if (buf_reload_i && state_reg == ST_STANDBY) begin
			sram_lost_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions and covers.
	////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	localparam int A_DEEP   = DEEP_ENTRY_CYC_P + 1;
	localparam int A_RESUME = DEEP_RESUME_CYC_P + 1;
	localparam int A_ULTRA  = ULTRA_ENTRY_CYC_P + 1;

	logic stb_cmd;
	assign stb_cmd = frame_end && frame_ok_reg && cmd_good && !busy_i &&
	                 state_reg == ST_STANDBY;

	property p_idle_standby;
		(state_reg == ST_STANDBY && cs_hi_s && !busy_i) |=> !active_o;
	endproperty
	a_idle_standby: assert property (p_idle_standby)
		else $error("Idle standby shows active.");

	property p_deep_ignore;
		(state_reg == ST_DEEP && frame_end && shift_reg != OP_DEEP_RESUME)
			|=> (state_reg == ST_DEEP);
	endproperty
	a_deep_ignore: assert property (p_deep_ignore)
		else $error("Deep mode left on a foreign opcode.");

	property p_deep_entry;
		(stb_cmd && shift_reg == OP_DEEP_ENTER)
			|=> (state_reg == ST_DEEP_ENTRY) ##[1:A_DEEP] (state_reg == ST_DEEP);
	endproperty
	a_deep_entry: assert property (p_deep_entry)
		else $error("Deep entry late or missing.");

	property p_abort;
		(state_reg == ST_STANDBY && frame_end && !cmd_good)
			|=> (state_reg == ST_STANDBY);
	endproperty
	a_abort: assert property (p_abort)
		else $error("Misaligned frame changed standby.");

	property p_reset_standby;
		$past(srst_i) |-> (state_reg == ST_STANDBY);
	endproperty
	a_reset_standby: assert property (p_reset_standby)
		else $error("Reset did not land in standby.");

	property p_busy_block;
		(state_reg == ST_STANDBY && frame_end && busy_i)
			|=> (state_reg == ST_STANDBY) [*2];
	endproperty
	a_busy_block: assert property (p_busy_block)
		else $error("Power-down entered while busy.");

	property p_resume;
		(state_reg == ST_DEEP && frame_end && frame_ok_reg && cmd_good &&
		 shift_reg == OP_DEEP_RESUME)
			|=> ##[1:A_RESUME] (state_reg == ST_STANDBY);
	endproperty
	a_resume: assert property (p_resume)
		else $error("Resume late or missing.");

	property p_resume_abort;
		(state_reg == ST_DEEP && frame_end && !cmd_good)
			|=> (state_reg == ST_DEEP);
	endproperty
	a_resume_abort: assert property (p_resume_abort)
		else $error("Bad resume frame left deep mode.");

	property p_sram_lost;
		(state_reg == ST_ULTRA) |-> sram_lost_o;
	endproperty
	a_sram_lost: assert property (p_sram_lost)
		else $error("Ultra mode without buffer loss flag.");

	property p_ultra_deaf;
		(state_reg == ST_ULTRA) |=> !cmd_enable_o;
	endproperty
	a_ultra_deaf: assert property (p_ultra_deaf)
		else $error("Commands enabled in ultra mode.");

	property p_ultra_entry;
		(stb_cmd && shift_reg == OP_ULTRA_ENTER)
			|=> ##[1:A_ULTRA] (state_reg == ST_ULTRA);
	endproperty
	a_ultra_entry: assert property (p_ultra_entry)
		else $error("Ultra entry late or missing.");

	property p_pulse_wake;
		(state_reg == ST_ULTRA_WAKE && frame_end && tmr_reg >= PULSE_LIM)
			|=> (state_reg == ST_ULTRA_EXIT);
	endproperty
	a_pulse_wake: assert property (p_pulse_wake)
		else $error("Valid wake pulse not taken.");

	property p_exit_ignore;
		(state_reg == ST_ULTRA_EXIT) |-> (!frame_ok_reg && tmr_reg <= EXIT_LIM);
	endproperty
	a_exit_ignore: assert property (p_exit_ignore)
		else $error("Frame live or timer overrun during ultra exit.");

	property p_early_bit;
		(state_reg == ST_ULTRA_WAKE && state_next == ST_STANDBY && any_s)
			|=> !frame_ok_reg;
	endproperty
	a_early_bit: assert property (p_early_bit)
		else $error("Early-bit command was not dropped.");

	property p_ready;
		ready_o == !$past(busy_i);
	endproperty
	a_ready: assert property (p_ready)
		else $error("Ready flag does not follow busy.");

	c_deep: cover property (state_reg == ST_DEEP_RESUME ##1
	                        state_reg == ST_DEEP_RESUME);
	c_ultra_pulse: cover property (state_reg == ST_ULTRA_EXIT);
	c_ultra_low: cover property (state_reg == ST_ULTRA_WAKE ##1
	                             state_reg == ST_STANDBY && !cs_hi_s);

endmodule

/* rtl/pd_sync.sv */
`timescale 1ns/1ps

// Two-flop synchroniser for a group of independent levels.
module pd_sync #(
	parameter int                 WIDTH   = 2,
	parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
	// Clock and reset of the receiving domain.
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	// Asynchronous levels in, synchronised levels out.
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	// First stage, read only by the second stage.
	logic [WIDTH-1:0] meta_reg;

	// Both stages load together; the second is the only reader of the first.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			meta_reg <= RST_VAL;
			sync_o   <= RST_VAL;
		end else begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end

endmodule

/* tb/flash_host_model.sv */
`timescale 1ns/1ps

// Host link master: owns chip select, serial clock and data in.
module flash_host_model (
	// Link pins towards the device.
	output logic sck_o,
	output logic cs_n_o,
	output logic mosi_o
);
	// Pins start idle: select high, clock low.
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// Select the device; the odd offset keeps the link phase apart.
	task automatic cs_low();
		#13;
		cs_n_o = 1'b0;
		#40;
	endtask
	// Shift n bits MSB first; the clock runs only inside frames.
	task automatic shift(input logic [15:0] d, input int n);
		for (int i = 0; i < n; i++) begin
			mosi_o = d[15 - i];
			#32 sck_o = 1'b1;
			#32 sck_o = 1'b0;
		end
	endtask
	// Deselect after the last bit, toggle data, keep the idle gap.
	task automatic cs_high();
		#32 cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		#60;
	endtask
	// A whole frame of n bits.
	task automatic frame(input logic [15:0] d, input int n);
		cs_low();
		shift(d, n);
		cs_high();
	endtask
	// Bare select pulse of the given length in ns.
	task automatic blip(input int ns);
		#13;
		cs_n_o = 1'b0;
		#(ns) cs_n_o = 1'b1;
		#60;
	endtask
endmodule

/* tb/flash_power_down_control_test.sv */
`timescale 1ns/1ps

// Compares a value with its expectation and counts the outcome.
`define CHK(a, b) begin \
	checks++; \
	if ((a) !== (b)) begin \
		err_total++; \
		$display("unexpected at %0t: got %h exp %h", $time, a, b); \
	end \
end

module flash_power_down_control_test;
	import flash_pd_pkg::*;
	// One frame case: busy level, bits, length, mode and buffer flag.
	typedef struct {
		logic        busy;
		logic [15:0] data;
		int          n;
		logic [1:0]  mode;
		logic        lost;
	} row_t;
	logic       core_clk_i   = 1'b0;
	logic       srst_i       = 1'b1;
	logic       busy_i       = 1'b0;
	logic       buf_reload_i = 1'b0;
	wire        sck;
	wire        cs_n;
	wire        mosi;
	logic [1:0] mode_o;
	logic       active_o;
	logic       ready_o;
	logic       cmd_enable_o;
	logic       sram_lost_o;
	int         err_total = 0;
	int         checks    = 0;
	int         cyc       = 0;
	// Cases run in order, each starting where the last one left off.
	row_t rows[10] = '{
		'{1'b0, 16'h_B900, 8, MODE_DEEP, 1'b0},
		'{1'b0, 16'h_7900, 8, MODE_DEEP, 1'b0},
		'{1'b0, 16'h_AB00, 7, MODE_DEEP, 1'b0},
		'{1'b0, 16'h_AB00, 12, MODE_DEEP, 1'b0},
		'{1'b0, 16'h_AB55, 16, MODE_STANDBY, 1'b0},
		'{1'b0, 16'h_B900, 7, MODE_STANDBY, 1'b0},
		'{1'b1, 16'h_B900, 8, MODE_STANDBY, 1'b0},
		'{1'b1, 16'h_7900, 8, MODE_STANDBY, 1'b0},
		'{1'b0, 16'h_7900, 12, MODE_STANDBY, 1'b0},
		'{1'b0, 16'h_79FF, 16, MODE_ULTRA, 1'b1}
	};

	////////////////////////////////////////////////////////////////////////
	// Clock, timeout and the device with short timers.
	////////////////////////////////////////////////////////////////////////

	always #4 core_clk_i = ~core_clk_i;

	// A hang counts as a mismatch and closes the run.
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end

	flash_host_model i_flash_host_model (
		.sck_o  (sck),
		.cs_n_o (cs_n),
		.mosi_o (mosi)
	);

	// Deep entry and the wake pulse keep their real counts; the rest are
	// shortened so that the exit waits fit the run.
	flash_power_down_control #(
		.DEEP_RESUME_CYC_P (4),
		.ULTRA_ENTRY_CYC_P (4),
		.ULTRA_EXIT_CYC_P  (20)
	) i_flash_power_down_control (
		.core_clk_i   (core_clk_i),
		.srst_i       (srst_i),
		.spi_sck_i    (sck),
		.spi_cs_n_i   (cs_n),
		.spi_mosi_i   (mosi),
		.busy_i       (busy_i),
		.buf_reload_i (buf_reload_i),
		.mode_o       (mode_o),
		.active_o     (active_o),
		.ready_o      (ready_o),
		.cmd_enable_o (cmd_enable_o),
		.sram_lost_o  (sram_lost_o)
	);

	// Waits n core edges, then steps just past the last one.
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	////////////////////////////////////////////////////////////////////////

	initial begin
		tick(8);
		srst_i = 1'b0;
		tick(4);
		// Table cases; busy rows are reissued without busy later.
		for (int i = 0; i < 10; i++) begin
			busy_i = rows[i].busy;
			i_flash_host_model.frame(rows[i].data, rows[i].n);
			tick(400);
			`CHK(mode_o, rows[i].mode)
			`CHK(sram_lost_o, rows[i].lost)
			`CHK(ready_o, ~rows[i].busy)
		end
		`CHK(cmd_enable_o, 1'b0)
		// Too short a pulse leaves the device asleep.
		i_flash_host_model.blip(8);
		tick(40);
		`CHK(mode_o, MODE_ULTRA)
		// Proper pulse, then a deep entry sent inside the exit wait.
		i_flash_host_model.blip(40);
		i_flash_host_model.frame(16'h_B900, 8);
		tick(40);
		`CHK(mode_o, MODE_STANDBY)
		// Back to ultra; an early byte wakes it but is dropped.
		i_flash_host_model.frame(16'h_7900, 8);
		tick(20);
		i_flash_host_model.frame(16'h_B900, 8);
		tick(40);
		`CHK(mode_o, MODE_STANDBY)
		`CHK(sram_lost_o, 1'b1)
		// Held select: a byte after the exit time is obeyed.
		i_flash_host_model.frame(16'h_7900, 8);
		tick(20);
		i_flash_host_model.cs_low();
		tick(30);
		i_flash_host_model.shift(16'h_B900, 8);
		i_flash_host_model.cs_high();
		tick(400);
		`CHK(mode_o, MODE_DEEP)
		i_flash_host_model.frame(16'h_AB00, 8);
		tick(20);
		// Buffer reload in standby clears the lost flag.
		buf_reload_i = 1'b1;
		tick(1);
		buf_reload_i = 1'b0;
		tick(3);
		`CHK(sram_lost_o, 1'b0)
		// Select low or busy makes the device active.
		`CHK(active_o, 1'b0)
		i_flash_host_model.cs_low();
		tick(5);
		`CHK(active_o, 1'b1)
		`CHK(cmd_enable_o, 1'b1)
		i_flash_host_model.shift(16'h_0300, 8);
		i_flash_host_model.cs_high();
		tick(10);
		`CHK(active_o, 1'b0)
		busy_i = 1'b1;
		tick(3);
		`CHK(active_o, 1'b1)
		`CHK(ready_o, 1'b0)
		busy_i = 1'b0;
		// Reset in ultra mode lands in standby with clean buffers.
		i_flash_host_model.frame(16'h_7900, 8);
		tick(20);
		srst_i = 1'b1;
		tick(8);
		srst_i = 1'b0;
		tick(2);
		`CHK(mode_o, MODE_STANDBY)
		`CHK(sram_lost_o, 1'b0)
		results();
	end
endmodule
